// >>> verilog/bbc_pkg.sv
// shared constants and types for the bit/branch/call/clear execution slice
package bbc_pkg;
  localparam logic [3:0] OP_BIT_INVERT = 4'h7;
  localparam logic [7:0] OP_BRANCH_OVF = 8'he4;
  localparam logic [6:0] OP_ZERO_REG = 7'h35;
  localparam logic [6:0] OP_CALL_FIRST = 7'h76;
  localparam logic [3:0] OP_CALL_SECOND = 4'hf;
  localparam int BIT_IDX_LSB = 9;
  localparam int BANK_SEL_POS = 8;
  localparam int SHADOW_POS = 8;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] CALL_RET_STEP = 21'h000004;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam int STACK_DEPTH = 31;
  localparam int STACK_AW = 5;
  localparam int DMEM_AW = 12;
  typedef enum logic [2:0] {
    ST_FETCH,
    ST_READ,
    ST_WRITE,
    ST_FLUSH,
    ST_CALL2
  } bbc_state_t;
endpackage

// >>> verilog/bbc_stack_if.sv
// push port between the sequencer and the return-address stack
`timescale 1ns/1ps
interface bbc_stack_if;
  logic push;
  logic [20:0] push_data;
  logic [20:0] top_data;
  logic [4:0] depth;
  modport core (output push, output push_data, input top_data, input depth);
  modport mem (input push, input push_data, output top_data, output depth);
endinterface

// >>> verilog/bbc_stack.sv
// hardware return-address stack with registered top-of-stack read
`timescale 1ns/1ps
module bbc_stack (
  input wire logic clk,
  input wire logic resetn,
  bbc_stack_if.mem sif
);
  logic [20:0] mem_q [bbc_pkg::STACK_DEPTH];
  logic [bbc_pkg::STACK_AW-1:0] ptr_q, ptr_d;
  logic [20:0] top_q, top_d;

  // next pointer and top; pushes past full wrap, matching a simple core
  always_comb begin
    ptr_d = ptr_q;
    top_d = top_q;
    if (sif.push) begin
      ptr_d = ptr_q + 5'h01;
      top_d = sif.push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ptr_q <= 5'h00;
      top_q <= bbc_pkg::PC_RESET;
    end else begin
      ptr_q <= ptr_d;
      top_q <= top_d;
    end
  end

  // storage carries no reset, only data
  always_ff @(posedge clk) begin
    if (sif.push && ptr_q < 5'(bbc_pkg::STACK_DEPTH)) begin
      mem_q[ptr_q] <= sif.push_data;
    end
  end

  assign sif.top_data = top_q;
  assign sif.depth = ptr_q;
endmodule

// >>> verilog/bbc_core.sv
// execution sequencer for bit invert, overflow branch, call and register zeroing
`timescale 1ns/1ps
module bbc_core (
  input wire logic clk,
  input wire logic resetn,
  input wire logic q_tick,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] dmem_rdata,
  input wire logic ovf_flag,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] flags_in,
  input wire logic [3:0] bank_pointer,
  input wire logic [7:0] access_bank_base,
  output logic [20:0] program_counter,
  output logic [bbc_pkg::DMEM_AW-1:0] dmem_addr,
  output logic [7:0] dmem_wdata,
  output logic dmem_we,
  output logic zero_set,
  output logic [7:0] accumulator_shadow,
  output logic [7:0] flags_shadow,
  output logic [3:0] bank_shadow,
  output logic [20:0] stack_top,
  output logic [4:0] stack_depth,
  output logic illegal_op
);
  // carrier between the sequencer and the return-address stack
  bbc_stack_if sif ();

  // sequencer state
  bbc_pkg::bbc_state_t state_q;
  bbc_pkg::bbc_state_t state_d;

  // program counter, always word aligned
  logic [20:0] pc_q;
  logic [20:0] pc_d;

  // first call word, kept until the second word arrives
  logic [20:0] call_pc_q;
  logic [20:0] call_pc_d;
  logic [7:0] call_lo_q;
  logic [7:0] call_lo_d;
  logic call_shadow_q;
  logic call_shadow_d;

  // bit index of a pending invert
  logic [2:0] bit_sel_q;
  logic [2:0] bit_sel_d;

  // data memory port
  logic [bbc_pkg::DMEM_AW-1:0] addr_q;
  logic [bbc_pkg::DMEM_AW-1:0] addr_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic we_q;
  logic we_d;

  // one-cycle status pulses
  logic zero_q;
  logic zero_d;
  logic illegal_q;
  logic illegal_d;

  // shadow copies taken on a call
  logic [7:0] acc_sh_q;
  logic [7:0] acc_sh_d;
  logic [7:0] flags_sh_q;
  logic [7:0] flags_sh_d;
  logic [3:0] bank_sh_q;
  logic [3:0] bank_sh_d;

  // stack push, same edge as the pc load so both land together
  logic push_d;
  logic [20:0] push_data_d;

  // data address from the 8-bit field and the bank-select flag
  // below the access boundary the low page is used, at or above it the high page
  function automatic logic [bbc_pkg::DMEM_AW-1:0] data_addr(
    input logic [7:0] f,
    input logic use_bank,
    input logic [3:0] bank,
    input logic [7:0] base
  );
    logic [3:0] page;
    if (use_bank) begin
      page = bank;
    end else if (f < base) begin
      page = 4'h0;
    end else begin
      page = 4'hf;
    end
    return {page, f};
  endfunction

  // incremented pc plus twice the signed offset
  function automatic logic [20:0] branch_target(
    input logic [20:0] pc,
    input logic [7:0] n
  );
    return pc + bbc_pkg::PC_STEP + {{12{n[7]}}, n, 1'b0};
  endfunction

  // one pc step past the current word
  function automatic logic [20:0] next_pc(
    input logic [20:0] pc
  );
    return pc + bbc_pkg::PC_STEP;
  endfunction

  // decode and sequencing; ticks arriving while a read-modify-write
  // is still in flight are lost, so ticks must be at least 3 clocks apart
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    call_pc_d = call_pc_q;
    call_lo_d = call_lo_q;
    call_shadow_d = call_shadow_q;
    bit_sel_d = bit_sel_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    we_d = 1'b0;
    zero_d = 1'b0;
    illegal_d = 1'b0;
    acc_sh_d = acc_sh_q;
    flags_sh_d = flags_sh_q;
    bank_sh_d = bank_sh_q;
    push_d = 1'b0;
    push_data_d = call_pc_q + bbc_pkg::CALL_RET_STEP;
    case (state_q)
      bbc_pkg::ST_FETCH: begin
        if (q_tick) begin
          if (instr_word[15:12] == bbc_pkg::OP_BIT_INVERT) begin
            // read phase follows; write lands before the next tick
            addr_d = data_addr(instr_word[7:0], instr_word[bbc_pkg::BANK_SEL_POS],
              bank_pointer, access_bank_base);
            bit_sel_d = instr_word[bbc_pkg::BIT_IDX_LSB +: 3];
            pc_d = next_pc(pc_q);
            state_d = bbc_pkg::ST_READ;
          end else if (instr_word[15:8] == bbc_pkg::OP_BRANCH_OVF) begin
            if (ovf_flag) begin
              pc_d = branch_target(pc_q, instr_word[7:0]);
              state_d = bbc_pkg::ST_FLUSH;
            end else begin
              pc_d = next_pc(pc_q);
            end
          end else if (instr_word[15:9] == bbc_pkg::OP_ZERO_REG) begin
            addr_d = data_addr(instr_word[7:0], instr_word[bbc_pkg::BANK_SEL_POS],
              bank_pointer, access_bank_base);
            wdata_d = bbc_pkg::BYTE_ZERO;
            we_d = 1'b1;
            zero_d = 1'b1;
            pc_d = next_pc(pc_q);
            state_d = bbc_pkg::ST_WRITE;
          end else if (instr_word[15:9] == bbc_pkg::OP_CALL_FIRST) begin
            call_pc_d = pc_q;
            call_lo_d = instr_word[7:0];
            call_shadow_d = instr_word[bbc_pkg::SHADOW_POS];
            pc_d = next_pc(pc_q);
            state_d = bbc_pkg::ST_CALL2;
          end else begin
            illegal_d = 1'b1;
            pc_d = next_pc(pc_q);
          end
        end
      end
      bbc_pkg::ST_READ: begin
        // only the selected bit changes
        wdata_d = dmem_rdata ^ (8'h01 << bit_sel_q);
        we_d = 1'b1;
        state_d = bbc_pkg::ST_WRITE;
      end
      bbc_pkg::ST_WRITE: begin
        state_d = bbc_pkg::ST_FETCH;
      end
      bbc_pkg::ST_FLUSH: begin
        // prefetched word is dropped, pc already holds the target
        if (q_tick) begin
          state_d = bbc_pkg::ST_FETCH;
        end
      end
      bbc_pkg::ST_CALL2: begin
        if (q_tick) begin
          if (instr_word[15:12] == bbc_pkg::OP_CALL_SECOND) begin
            push_d = 1'b1;
            pc_d = {instr_word[11:0], call_lo_q, 1'b0};
            if (call_shadow_q) begin
              acc_sh_d = accumulator;
              flags_sh_d = flags_in;
              bank_sh_d = bank_pointer;
            end
          end else begin
            // a broken pair is refused rather than half executed
            illegal_d = 1'b1;
            pc_d = next_pc(pc_q);
          end
          state_d = bbc_pkg::ST_FETCH;
        end
      end
      default: begin
        state_d = bbc_pkg::ST_FETCH;
      end
    endcase
  end

  // registers only; synchronous reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= bbc_pkg::ST_FETCH;
      pc_q <= bbc_pkg::PC_RESET;
      call_pc_q <= bbc_pkg::PC_RESET;
      call_lo_q <= bbc_pkg::BYTE_ZERO;
      call_shadow_q <= 1'b0;
      bit_sel_q <= 3'h0;
      addr_q <= 12'h000;
      wdata_q <= bbc_pkg::BYTE_ZERO;
      we_q <= 1'b0;
      zero_q <= 1'b0;
      illegal_q <= 1'b0;
      acc_sh_q <= bbc_pkg::BYTE_ZERO;
      flags_sh_q <= bbc_pkg::BYTE_ZERO;
      bank_sh_q <= bbc_pkg::BANK_RESET;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      call_pc_q <= call_pc_d;
      call_lo_q <= call_lo_d;
      call_shadow_q <= call_shadow_d;
      bit_sel_q <= bit_sel_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      zero_q <= zero_d;
      illegal_q <= illegal_d;
      acc_sh_q <= acc_sh_d;
      flags_sh_q <= flags_sh_d;
      bank_sh_q <= bank_sh_d;
    end
  end

  // return-address stack
  bbc_stack u_stack (
    .clk(clk),
    .resetn(resetn),
    .sif(sif)
  );

  // stack request is combinational inside the block only
  assign sif.push = push_d;
  assign sif.push_data = push_data_d;

  // outputs straight from flops
  assign program_counter = pc_q;
  assign dmem_addr = addr_q;
  assign dmem_wdata = wdata_q;
  assign dmem_we = we_q;
  assign zero_set = zero_q;
  assign accumulator_shadow = acc_sh_q;
  assign flags_shadow = flags_sh_q;
  assign bank_shadow = bank_sh_q;
  assign stack_top = sif.top_data;
  assign stack_depth = sif.depth;
  assign illegal_op = illegal_q;
endmodule

// >>> dv/bbc_core_asserts.sv
// port checks for the execution slice
`timescale 1ns/1ps
module bbc_core_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [20:0] program_counter,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_wdata,
  input wire logic zero_set,
  input wire logic [4:0] stack_depth,
  input wire logic [7:0] accumulator_shadow
);
  property p_rst;
    @(posedge clk) !resetn |=> program_counter == bbc_pkg::PC_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("pc not cleared");
  // word aligned targets only
  property p_even;
    @(posedge clk) disable iff (!resetn) program_counter[0] == 1'b0;
  endproperty
  a_even: assert property (p_even) else $error("odd pc");
  // zeroing writes a zero byte in the same cycle
  property p_zero_we;
    @(posedge clk) disable iff (!resetn) zero_set |-> dmem_we && dmem_wdata == 8'h00;
  endproperty
  a_zero_we: assert property (p_zero_we) else $error("zeroing without store");
  // a write is a single-cycle strobe
  property p_we_pulse;
    @(posedge clk) disable iff (!resetn) dmem_we |=> !dmem_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("store held");
  // stack only grows by one per call
  property p_stack_step;
    @(posedge clk) disable iff (!resetn)
      $changed(stack_depth) |-> stack_depth == $past(stack_depth) + 5'h01;
  endproperty
  a_stack_step: assert property (p_stack_step) else $error("bad stack step");
  // the accumulator shadow only moves together with a push
  property p_shadow_call;
    @(posedge clk) disable iff (!resetn) $changed(accumulator_shadow) |-> $changed(stack_depth);
  endproperty
  a_shadow_call: assert property (p_shadow_call) else $error("shadow outside call");
endmodule
bind bbc_core bbc_core_asserts u_chk (.clk(clk), .resetn(resetn),
  .program_counter(program_counter), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
  .zero_set(zero_set), .stack_depth(stack_depth), .accumulator_shadow(accumulator_shadow));

// >>> dv/tb_bbc_core.sv
// bench for the execution slice
`timescale 1ns/1ps
module tb_bbc_core;
  logic clk = 0;
  logic resetn = 0;
  logic tick = 1'b0;
  logic [15:0] w = 16'h0000;
  logic [7:0] rd = 8'h00;
  logic ovf = 1'b0;
  logic [7:0] acc = 8'h00;
  logic [7:0] flg = 8'h00;
  logic [3:0] bank = 4'h0;
  logic [20:0] pc;
  logic [11:0] addr;
  logic [7:0] wd;
  logic we;
  logic zs;
  logic [7:0] acc_sh;
  logic [7:0] flg_sh;
  logic [3:0] bank_sh;
  logic [20:0] top;
  logic [4:0] depth;
  logic ill;
  logic [20:0] exp_pc = 21'h000000;
  logic [20:0] call_pc;
  logic seen_we;
  logic seen_zs;
  logic seen_ill;
  logic [7:0] seen_wd;
  logic [11:0] seen_addr;
  int fail_count = 0;
  int checks_done = 0;
  bbc_core u_dut (.clk(clk), .resetn(resetn), .q_tick(tick), .instr_word(w),
    .dmem_rdata(rd), .ovf_flag(ovf), .accumulator(acc), .flags_in(flg),
    .bank_pointer(bank), .access_bank_base(8'h60), .program_counter(pc),
    .dmem_addr(addr), .dmem_wdata(wd), .dmem_we(we), .zero_set(zs),
    .accumulator_shadow(acc_sh), .flags_shadow(flg_sh), .bank_shadow(bank_sh),
    .stack_top(top), .stack_depth(depth), .illegal_op(ill));
  initial forever #5 clk = ~clk;
  task test_done;
    $display("fails %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      fail_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, expv);
    end
  endtask
  // one instruction cycle of four clocks; records what the data port did
  task automatic run_op(input logic [15:0] iw);
    @(posedge clk);
    w <= iw;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    seen_we = 1'b0;
    seen_zs = 1'b0;
    seen_ill = 1'b0;
    seen_wd = 8'hff;
    seen_addr = 12'hfff;
    repeat (3) begin
      @(negedge clk);
      if (we === 1'b1) begin
        seen_we = 1'b1;
        seen_wd = wd;
        seen_addr = addr;
      end
      if (zs === 1'b1) seen_zs = 1'b1;
      if (ill === 1'b1) seen_ill = 1'b1;
    end
  endtask
  task automatic t_zero;
    @(posedge clk);
    bank <= 4'h3;
    run_op({bbc_pkg::OP_ZERO_REG, 1'b1, 8'h10});
    exp_pc = exp_pc + bbc_pkg::PC_STEP;
    check(seen_we, 1'b1);
    check(seen_wd, 8'h00);
    check(seen_addr, 12'h310);
    check(seen_zs, 1'b1);
    check(pc, exp_pc);
  endtask
  task automatic t_invert;
    @(posedge clk);
    rd <= 8'h75;
    run_op({bbc_pkg::OP_BIT_INVERT, 3'h4, 1'b0, 8'h20});
    exp_pc = exp_pc + bbc_pkg::PC_STEP;
    check(seen_we, 1'b1);
    check(seen_wd, 8'h65);
    check(seen_addr, 12'h020);
    check(seen_zs, 1'b0);
    check(pc, exp_pc);
  endtask
  task automatic t_bov_idle;
    @(posedge clk);
    ovf <= 1'b0;
    run_op({bbc_pkg::OP_BRANCH_OVF, 8'h05});
    exp_pc = exp_pc + bbc_pkg::PC_STEP;
    check(pc, exp_pc);
    check(seen_we, 1'b0);
  endtask
  task automatic t_bov_jump;
    @(posedge clk);
    ovf <= 1'b1;
    run_op({bbc_pkg::OP_BRANCH_OVF, 8'hfd});
    exp_pc = exp_pc + 21'h000002 - 21'h000006;
    check(pc, exp_pc);
    run_op({bbc_pkg::OP_ZERO_REG, 1'b1, 8'h10});
    check(seen_we, 1'b0);
    check(pc, exp_pc);
    @(posedge clk);
    ovf <= 1'b0;
  endtask
  task automatic t_call;
    @(posedge clk);
    acc <= 8'ha5;
    flg <= 8'h3c;
    call_pc = exp_pc;
    run_op({bbc_pkg::OP_CALL_FIRST, 1'b1, 8'h34});
    check(depth, 5'h00);
    check(pc, call_pc + 21'h000002);
    run_op({bbc_pkg::OP_CALL_SECOND, 12'h012});
    exp_pc = 21'h002468;
    check(pc, exp_pc);
    check(top, call_pc + 21'h000004);
    check(depth, 5'h01);
    check(acc_sh, 8'ha5);
    check(flg_sh, 8'h3c);
    check(bank_sh, 4'h3);
  endtask
  task automatic t_illegal;
    run_op(16'h0000);
    exp_pc = exp_pc + bbc_pkg::PC_STEP;
    check(seen_ill, 1'b1);
    check(seen_we, 1'b0);
    check(pc, exp_pc);
    run_op({bbc_pkg::OP_CALL_FIRST, 1'b0, 8'h11});
    run_op(16'h0000);
    exp_pc = exp_pc + 21'h000004;
    check(seen_ill, 1'b1);
    check(depth, 5'h01);
    check(pc, exp_pc);
  endtask
  task automatic t_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    exp_pc = 21'h000000;
    check(pc, exp_pc);
    check(depth, 5'h00);
    check(top, 21'h000000);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_zero;
    t_invert;
    t_bov_idle;
    t_bov_jump;
    t_call;
    t_illegal;
    t_reset;
    t_invert;
    test_done;
  end
  // about 60 clocks of tests; generous margin
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    test_done;
  end
endmodule
